// ==== bench/atrc_pin_src.sv ====
// Trigger pin source that keeps each level for the minimum hold time
`timescale 1ns/1ps
module atrc_pin_src (
   input  wire logic [1:0] want,
   input  wire logic       aclk,
   output logic      [1:0] pins
);
   int held [2];
   initial begin
      pins = 2'b00;
      held = '{8, 8};
   end
   always @(posedge aclk) begin
      for (int i = 0; i < 2; i++) begin
         if (pins[i] !== want[i] && held[i] >= atrc_pkg::PIN_HOLD_CYCLES) begin
            pins[i] <= want[i];
            held[i] <= 1;
         end else begin
            held[i] <= held[i] + 1;
         end
      end
   end
endmodule

// ==== bench/atrc_props.sv ====
// Checker for bus handshakes, toggle pin enable and interrupt vectors
`timescale 1ns/1ps
module atrc_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic toggle_port_latch,
   input wire logic toggle_port_dir,
   input wire logic core_toggle_pin_oe_n,
   input wire logic aux_a_vector,
   input wire logic core_vector,
   input wire logic aux_b_vector
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_port_off;
      !(toggle_port_latch && toggle_port_dir) [*2];
   endsequence
   property p_wr_answer;
      s_wr_taken |=> ##1 s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response late");
   property p_rd_answer;
      s_rd_taken |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
   property p_r_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_r_block: assert property (p_r_block) else $error("read accepted while busy");
   property p_w_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_w_block: assert property (p_w_block) else $error("write accepted while busy");
   // Port bits low keep the pin undriven
   property p_oe;
      s_port_off |-> core_toggle_pin_oe_n;
   endproperty
   a_oe: assert property (p_oe) else $error("toggle pin driven");
   // Flags only fall through a register write
   property p_vec_hold;
      $fell(aux_a_vector) || $fell(core_vector) || $fell(aux_b_vector) |-> s_axi_bvalid || $past(s_axi_bvalid);
   endproperty
   a_vec_hold: assert property (p_vec_hold) else $error("vector fell without write");
endmodule
bind atrc_top atrc_props u_atrc_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .toggle_port_latch(toggle_port_latch), .toggle_port_dir(toggle_port_dir),
   .core_toggle_pin_oe_n(core_toggle_pin_oe_n), .aux_a_vector(aux_a_vector),
   .core_vector(core_vector), .aux_b_vector(aux_b_vector));

// ==== bench/aux_timer_reload_capture_tb.sv ====
// Self-checking bench for the reload and capture timer block
`timescale 1ns/1ps
module aux_timer_reload_capture_tb;
   localparam logic [7:0] CC = atrc_pkg::OFS_CORE_CTRL;
   localparam logic [7:0] AC = atrc_pkg::OFS_AUX_A_CTRL;
   localparam logic [7:0] BC = atrc_pkg::OFS_AUX_B_CTRL;
   localparam logic [7:0] CT = atrc_pkg::OFS_CORE_TIMER;
   localparam logic [7:0] AV = atrc_pkg::OFS_AUX_A;
   localparam logic [7:0] BV = atrc_pkg::OFS_AUX_B;
   localparam logic [7:0] IR = atrc_pkg::OFS_IRQ_CTRL;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        latch = 1'b0, dir = 1'b0;
   logic [1:0]  want = 2'b00;
   logic        awready, wready, bvalid, arready, rvalid, tpin, tpin_oe_n, vec_a, vec_c, vec_b;
   logic [1:0]  bresp, rresp, last_resp, pins;
   logic [31:0] rdata;
   int          n_mismatch = 0, compares = 0, cyc = 0;
   always #10 aclk = ~aclk;
   atrc_top #(.PRESCALE(2)) u_atrc_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .aux_a_input_pin(pins[0]), .aux_b_input_pin(pins[1]),
      .toggle_port_latch(latch), .toggle_port_dir(dir), .core_toggle_pin(tpin),
      .core_toggle_pin_oe_n(tpin_oe_n), .aux_a_vector(vec_a), .core_vector(vec_c), .aux_b_vector(vec_b));
   atrc_pin_src u_atrc_pin_src (.want(want), .aclk(aclk), .pins(pins));
   task automatic final_report();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc > 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // Answers are sampled at the falling edge so the release lands just after the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      aw = 1'b1;
      w = 1'b1;
      b = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b0;
      while (!(b && bready)) begin
         @(negedge aclk);
         aw = aw && !awready;
         w = w && !wready;
         b = bvalid;
         last_resp = bresp;
         @(posedge aclk);
         awvalid <= aw;
         wvalid <= w;
         bready <= b && !bready;
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic ar, r;
      ar = 1'b1;
      r = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b0;
      while (!(r && rready)) begin
         @(negedge aclk);
         ar = ar && !arready;
         r = rvalid;
         d = rdata;
         last_resp = rresp;
         @(posedge aclk);
         arvalid <= ar;
         rready <= r && !rready;
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(n, e, v);
   endtask
   task automatic wait_flag(input int i);
      logic [31:0] v;
      v = 32'h0000_0000;
      for (int k = 0; k < 60 && v[i] !== 1'b1; k++) rd(IR, v);
   endtask
   task automatic core_above(input logic [15:0] lo);
      logic [31:0] v;
      for (int k = 0; k < 5; k++) begin
         rd(CT, v);
         chk("core range", 32'h0000_0001, 32'(v[15:0] >= lo));
      end
   endtask
   function automatic logic [31:0] actl(input logic [2:0] m, input logic [2:0] s);
      return 32'({1'b1, m, s});
   endfunction
   task automatic t_reset();
      logic [31:0] v;
      for (int a = 0; a <= 24; a += 4) rchk("reset", 8'(a), 32'h0000_0000);
      rd(8'h1C, v);
      chk("hole data", 32'h0000_0000, v);
      chk("hole rresp", 32'(atrc_pkg::RESP_SLVERR), 32'(last_resp));
      wr(8'h1C, 32'h0000_FFFF);
      chk("hole bresp", 32'(atrc_pkg::RESP_SLVERR), 32'(last_resp));
      chk("oe_n", 32'h0000_0001, 32'(tpin_oe_n));
   endtask
   task automatic t_capture();
      wr(CT, 32'h0000_1234);
      wr(AC, actl(3'b101, 3'b101));
      want[0] <= 1'b1;
      wait_flag(0);
      rchk("capture", AV, 32'h0000_1234);
      rchk("flags", IR, 32'h0000_0001);
      wr(CT, 32'h0000_2222);
      want[0] <= 1'b0;
   endtask
   task automatic t_pin_reload();
      wr(BV, 32'h0000_ABCD);
      wr(CT, 32'h0000_0000);
      wr(BC, actl(3'b100, 3'b001));
      want[1] <= 1'b1;
      wait_flag(2);
      rchk("reload", CT, 32'h0000_ABCD);
      rchk("aux b", BV, 32'h0000_ABCD);
      rchk("falling", AV, 32'h0000_1234);
      rchk("flags", IR, 32'h0000_0005);
   endtask
   task automatic t_vectors();
      wr(IR, 32'h0000_0075);
      @(negedge aclk);
      chk("vectors", 32'h0000_0005, 32'({vec_b, vec_c, vec_a}));
      wr(IR, 32'h0000_0070);
      @(negedge aclk);
      chk("vectors", 32'h0000_0000, 32'({vec_b, vec_c, vec_a}));
   endtask
   task automatic t_sw_toggle();
      wr(CT, 32'h0000_0100);
      wr(AV, 32'h0000_7777);
      wr(AC, actl(3'b100, 3'b111));
      wr(BC, 32'h0000_0000);
      wr(CC, 32'h0000_000C);
      latch <= 1'b1;
      dir <= 1'b1;
      repeat (2) @(negedge aclk);
      chk("pin", 32'h0000_0002, 32'({tpin, tpin_oe_n}));
      rchk("core", CT, 32'h0000_0100);
      rchk("flags", IR, 32'h0000_0070);
      dir <= 1'b0;
      repeat (2) @(negedge aclk);
      chk("oe_n", 32'h0000_0001, 32'(tpin_oe_n));
   endtask
   // Rising edge reloads from a, falling from b, then both on the same trigger
   task automatic t_tl_reload();
      wr(CC, 32'h0000_0000);
      wr(AV, 32'h0000_FFFE);
      wr(BV, 32'h0000_FFF0);
      wr(AC, actl(3'b100, 3'b101));
      wr(BC, actl(3'b100, 3'b110));
      wr(CT, 32'h0000_FFF0);
      wr(IR, 32'h0000_0070);
      wr(CC, 32'h0000_0001);
      wait_flag(0);
      wait_flag(2);
      rchk("flags", IR, 32'h0000_0077);
      core_above(16'hFFF0);
      wr(CC, 32'h0000_0000);
      wr(AV, 32'h0000_1111);
      wr(AC, actl(3'b100, 3'b111));
      wr(BC, actl(3'b100, 3'b111));
      wr(CT, 32'h0000_FFF0);
      wr(IR, 32'h0000_0070);
      wr(CC, 32'h0000_0001);
      wait_flag(2);
      core_above(16'hFFF0);
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_capture();
      t_pin_reload();
      t_vectors();
      t_sw_toggle();
      t_tl_reload();
      final_report();
   end
endmodule

// ==== rtl/atrc_aux.sv ====
// One auxiliary timer: trigger decode, own counting and register storage
`timescale 1ns/1ps
module atrc_aux #(
   parameter int WIDTH = 16
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [2:0]       aux_mode_field,
   input  wire logic [2:0]       aux_input_select,
   input  wire logic             run_flag,
   input  wire logic             count_down,
   input  wire logic             pin_rise,
   input  wire logic             pin_fall,
   input  wire logic             tl_rise,
   input  wire logic             tl_fall,
   input  wire logic             tick,
   input  wire logic [WIDTH-1:0] core_value,
   input  wire logic             sw_write,
   input  wire logic [WIDTH-1:0] sw_data,
   output logic [WIDTH-1:0]      value,
   output logic                  reload_req,
   output logic                  event_set
);
   logic [WIDTH-1:0] next_value;
   logic             trig;
   logic             capt;
   logic             counting;
   logic             wrap;

   function automatic logic sel_edge(input logic [1:0] sel, input logic r, input logic f);
      sel_edge = (sel[0] & r) | (sel[1] & f);
   endfunction

   always_comb begin
      trig = aux_input_select[2] ? sel_edge(aux_input_select[1:0], tl_rise, tl_fall)
                                 : sel_edge(aux_input_select[1:0], pin_rise, pin_fall);
      capt = sel_edge(aux_input_select[1:0], pin_rise, pin_fall);
      // no count in reload or capture
      case (aux_mode_field)
         atrc_pkg::ATRC_MODE_TIMER:   counting = run_flag & tick;
         atrc_pkg::ATRC_MODE_COUNTER: counting = run_flag & trig;
         default:                     counting = 1'b0;
      endcase
      wrap = counting & (count_down ? (value == atrc_pkg::TIMER_RESET) : (value == atrc_pkg::TIMER_MAX));
      reload_req = (aux_mode_field == atrc_pkg::ATRC_MODE_RELOAD) & trig;
      next_value = value;
      if (sw_write) begin
         next_value = sw_data;
      end
      if (counting) begin
         next_value = count_down ? WIDTH'(value - 1'b1) : WIDTH'(value + 1'b1);
      end
      if ((aux_mode_field == atrc_pkg::ATRC_MODE_CAPTURE) && capt) begin
         next_value = core_value;
      end
      event_set = wrap | reload_req | ((aux_mode_field == atrc_pkg::ATRC_MODE_CAPTURE) & capt);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         value <= '0;
      end else begin
         value <= next_value;
      end
   end
endmodule

// ==== rtl/atrc_edge.sv ====
// Two-flop synchroniser and edge detector for one auxiliary input pin
`timescale 1ns/1ps
module atrc_edge (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic sync1;
   logic sync2;
   logic prev;
   logic next_sync1;
   logic next_sync2;
   logic next_prev;

   always_comb begin
      next_sync1 = pin;
      next_sync2 = sync1;
      next_prev  = sync2;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev  <= 1'b0;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         prev  <= next_prev;
      end
   end

   assign level = prev;
   assign rise  = sync2 & ~prev;
   assign fall  = ~sync2 & prev;
endmodule

// ==== rtl/atrc_pkg.sv ====
// Package with register map, field layout and mode codes for the auxiliary timer reload/capture block
package atrc_pkg;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] OFS_CORE_CTRL  = 8'h00;
   localparam logic [7:0] OFS_AUX_A_CTRL = 8'h04;
   localparam logic [7:0] OFS_AUX_B_CTRL = 8'h08;
   localparam logic [7:0] OFS_CORE_TIMER = 8'h0C;
   localparam logic [7:0] OFS_AUX_A      = 8'h10;
   localparam logic [7:0] OFS_AUX_B      = 8'h14;
   localparam logic [7:0] OFS_IRQ_CTRL   = 8'h18;
   // Aux control register fields
   localparam int AUX_SEL_LSB  = 0;
   localparam int AUX_MODE_LSB = 3;
   localparam int AUX_RUN_BIT  = 6;
   localparam int AUX_UD_BIT   = 7;
   // Core control register fields
   localparam int CORE_RUN_BIT = 0;
   localparam int CORE_UD_BIT  = 1;
   localparam int CORE_OE_BIT  = 2;
   localparam int CORE_TL_BIT  = 3;
   // Interrupt control register fields: flags then enables
   localparam int IRQ_FLAG_LSB = 0;
   localparam int IRQ_EN_LSB   = 4;
   localparam logic [15:0] TIMER_RESET = 16'h0000;
   localparam logic [15:0] TIMER_MAX   = 16'hFFFF;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   // Minimum pin level hold time in CPU clock cycles
   localparam int PIN_HOLD_CYCLES = 8;
   typedef enum logic [2:0] {
      ATRC_MODE_TIMER   = 3'b000,
      ATRC_MODE_COUNTER = 3'b001,
      ATRC_MODE_RELOAD  = 3'b100,
      ATRC_MODE_CAPTURE = 3'b101
   } atrc_mode_t;
endpackage

// ==== rtl/atrc_top.sv ====
// Core timer, toggle latch, two auxiliary timers with reload/capture, and AXI4-Lite registers
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Aux mode 100 makes it a reload source for the core timer.
// - Reload trigger picked by input select: pin edge or toggle latch edge.
// - Aux timer in reload mode never counts.
// - Reload copies aux value into core and sets aux flag.
// - Toggle-latch triggered reload also sets the core flag.
// - Software writes to toggle latch never trigger reloads or counts.
// - Both edges reload every wrap; one edge every second wrap.
// - Rising/falling split gives alternating reloads for PWM.
// - Same trigger on both: second aux timer wins.
// - Toggle pin driven when enable, port latch and direction all set.
// - Aux mode 101 captures core value on selected pin edge.
// - Capture uses two low select bits; top bit ignored.
// - Aux timer in capture mode never counts.
// - Capture sets aux flag together with storing the value.
// - Each timer sets its flag on FFFF/0000 wrap.
// - Set flag with enable raises that timer's vector request.
// - Select x00 none; 0xx pin edges; 1xx toggle latch edges.
// - Toggle latch inverts on each core wrap.
module atrc_top #(
   parameter int PRESCALE = 8
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        aux_a_input_pin,
   input  wire logic        aux_b_input_pin,
   input  wire logic        toggle_port_latch,
   input  wire logic        toggle_port_dir,
   output logic             core_toggle_pin,
   output logic             core_toggle_pin_oe_n,
   output logic             aux_a_vector,
   output logic             core_vector,
   output logic             aux_b_vector
);
   logic [7:0]  aux_a_ctrl;
   logic [7:0]  aux_b_ctrl;
   logic [3:0]  core_ctrl;
   logic [15:0] core_timer;
   logic [2:0]  irq_flag;
   logic [2:0]  irq_en;
   logic [15:0] prescale_cnt;
   logic [7:0]  next_aux_a_ctrl;
   logic [7:0]  next_aux_b_ctrl;
   logic [3:0]  next_core_ctrl;
   logic [15:0] next_core_timer;
   logic [2:0]  next_irq_flag;
   logic [2:0]  next_irq_en;
   logic [15:0] next_prescale_cnt;
   logic        tick;
   logic        core_wrap;
   logic        tl_rise;
   logic        tl_fall;
   logic        a_rise;
   logic        a_fall;
   logic        b_rise;
   logic        b_fall;
   logic [15:0] aux_a_value;
   logic [15:0] aux_b_value;
   logic        a_reload;
   logic        b_reload;
   logic        a_event;
   logic        b_event;
   logic        wr_fire;
   logic        rd_fire;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        next_aw_held;
   logic        next_w_held;
   logic [7:0]  next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   logic        wr_a;
   logic        wr_b;
   logic        wr_core;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == atrc_pkg::OFS_CORE_CTRL) || (a == atrc_pkg::OFS_AUX_A_CTRL) ||
                (a == atrc_pkg::OFS_AUX_B_CTRL) || (a == atrc_pkg::OFS_CORE_TIMER) ||
                (a == atrc_pkg::OFS_AUX_A) || (a == atrc_pkg::OFS_AUX_B) ||
                (a == atrc_pkg::OFS_IRQ_CTRL);
   endfunction

   // Byte-lane merge of a write into a 32-bit image
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            old[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      merge = old;
   endfunction

   atrc_edge u_edge_a (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (aux_a_input_pin),
      .level   (),
      .rise    (a_rise),
      .fall    (a_fall)
   );

   atrc_edge u_edge_b (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (aux_b_input_pin),
      .level   (),
      .rise    (b_rise),
      .fall    (b_fall)
   );

   atrc_aux u_aux_a (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .aux_mode_field   (aux_a_ctrl[atrc_pkg::AUX_MODE_LSB +: 3]),
      .aux_input_select (aux_a_ctrl[atrc_pkg::AUX_SEL_LSB +: 3]),
      .run_flag         (aux_a_ctrl[atrc_pkg::AUX_RUN_BIT]),
      .count_down       (aux_a_ctrl[atrc_pkg::AUX_UD_BIT]),
      .pin_rise         (a_rise),
      .pin_fall         (a_fall),
      .tl_rise          (tl_rise),
      .tl_fall          (tl_fall),
      .tick             (tick),
      .core_value       (core_timer),
      .sw_write         (wr_a),
      .sw_data          (16'(merge({16'h0000, aux_a_value}, w_data, w_strb))),
      .value            (aux_a_value),
      .reload_req       (a_reload),
      .event_set        (a_event)
   );

   atrc_aux u_aux_b (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .aux_mode_field   (aux_b_ctrl[atrc_pkg::AUX_MODE_LSB +: 3]),
      .aux_input_select (aux_b_ctrl[atrc_pkg::AUX_SEL_LSB +: 3]),
      .run_flag         (aux_b_ctrl[atrc_pkg::AUX_RUN_BIT]),
      .count_down       (aux_b_ctrl[atrc_pkg::AUX_UD_BIT]),
      .pin_rise         (b_rise),
      .pin_fall         (b_fall),
      .tl_rise          (tl_rise),
      .tl_fall          (tl_fall),
      .tick             (tick),
      .core_value       (core_timer),
      .sw_write         (wr_b),
      .sw_data          (16'(merge({16'h0000, aux_b_value}, w_data, w_strb))),
      .value            (aux_b_value),
      .reload_req       (b_reload),
      .event_set        (b_event)
   );

   // Timer logic
   always_comb begin
      tick = (prescale_cnt == 16'(PRESCALE - 1));
      next_prescale_cnt = tick ? 16'h0000 : 16'(prescale_cnt + 1'b1);
      // core wrap at the count limits
      core_wrap = core_ctrl[atrc_pkg::CORE_RUN_BIT] & tick &
                  (core_ctrl[atrc_pkg::CORE_UD_BIT] ? (core_timer == atrc_pkg::TIMER_RESET)
                                                   : (core_timer == atrc_pkg::TIMER_MAX));
      // only hardware wraps give latch edges
      tl_rise = core_wrap & ~core_ctrl[atrc_pkg::CORE_TL_BIT];
      tl_fall = core_wrap & core_ctrl[atrc_pkg::CORE_TL_BIT];
      wr_core = wr_fire && (aw_addr == atrc_pkg::OFS_CORE_TIMER);
      wr_a    = wr_fire && (aw_addr == atrc_pkg::OFS_AUX_A);
      wr_b    = wr_fire && (aw_addr == atrc_pkg::OFS_AUX_B);
      next_core_ctrl  = core_ctrl;
      next_aux_a_ctrl = aux_a_ctrl;
      next_aux_b_ctrl = aux_b_ctrl;
      next_irq_en     = irq_en;
      next_irq_flag   = irq_flag;
      next_core_timer = core_timer;
      if (wr_fire && (aw_addr == atrc_pkg::OFS_CORE_CTRL)) begin
         next_core_ctrl = 4'(merge(32'(core_ctrl), w_data, w_strb));
      end
      if (wr_fire && (aw_addr == atrc_pkg::OFS_AUX_A_CTRL)) begin
         next_aux_a_ctrl = 8'(merge(32'(aux_a_ctrl), w_data, w_strb));
      end
      if (wr_fire && (aw_addr == atrc_pkg::OFS_AUX_B_CTRL)) begin
         next_aux_b_ctrl = 8'(merge(32'(aux_b_ctrl), w_data, w_strb));
      end
      if (wr_fire && (aw_addr == atrc_pkg::OFS_IRQ_CTRL) && w_strb[0]) begin
         next_irq_flag = w_data[atrc_pkg::IRQ_FLAG_LSB +: 3];
         next_irq_en   = w_data[atrc_pkg::IRQ_EN_LSB +: 3];
      end
      if (wr_core) begin
         next_core_timer = 16'(merge({16'h0000, core_timer}, w_data, w_strb));
      end
      if (core_ctrl[atrc_pkg::CORE_RUN_BIT] && tick) begin
         next_core_timer = core_ctrl[atrc_pkg::CORE_UD_BIT] ? 16'(core_timer - 1'b1) : 16'(core_timer + 1'b1);
      end
      if (core_wrap) begin
         next_core_ctrl[atrc_pkg::CORE_TL_BIT] = ~core_ctrl[atrc_pkg::CORE_TL_BIT];
      end
      if (a_reload) begin
         next_core_timer = aux_a_value;
      end
      if (b_reload) begin
         next_core_timer = aux_b_value;
      end
      if (a_event) begin
         next_irq_flag[0] = 1'b1;
      end
      if (core_wrap) begin
         next_irq_flag[1] = 1'b1;
      end
      if (b_event) begin
         next_irq_flag[2] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_ctrl    <= '0;
         aux_a_ctrl   <= '0;
         aux_b_ctrl   <= '0;
         irq_en       <= '0;
         irq_flag     <= '0;
         core_timer   <= atrc_pkg::TIMER_RESET;
         prescale_cnt <= 16'h0000;
      end else begin
         core_ctrl    <= next_core_ctrl;
         aux_a_ctrl   <= next_aux_a_ctrl;
         aux_b_ctrl   <= next_aux_b_ctrl;
         irq_en       <= next_irq_en;
         irq_flag     <= next_irq_flag;
         core_timer   <= next_core_timer;
         prescale_cnt <= next_prescale_cnt;
      end
   end

   // toggle pin drive, enable active low
   assign core_toggle_pin      = core_ctrl[atrc_pkg::CORE_TL_BIT];
   assign core_toggle_pin_oe_n = ~(core_ctrl[atrc_pkg::CORE_OE_BIT] & toggle_port_latch & toggle_port_dir);
   assign aux_a_vector = irq_flag[0] & irq_en[0];
   assign core_vector  = irq_flag[1] & irq_en[1];
   assign aux_b_vector = irq_flag[2] & irq_en[2];

   // AXI4-Lite slave: address and data latched independently, response after both
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;

   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = addr_ok(aw_addr) ? atrc_pkg::RESP_OKAY : atrc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (rd_fire) begin
         next_rvalid = 1'b1;
         next_rresp  = addr_ok(s_axi_araddr) ? atrc_pkg::RESP_OKAY : atrc_pkg::RESP_SLVERR;
         case (s_axi_araddr)
            atrc_pkg::OFS_CORE_CTRL:  next_rdata = 32'(core_ctrl);
            atrc_pkg::OFS_AUX_A_CTRL: next_rdata = 32'(aux_a_ctrl);
            atrc_pkg::OFS_AUX_B_CTRL: next_rdata = 32'(aux_b_ctrl);
            atrc_pkg::OFS_CORE_TIMER: next_rdata = 32'(core_timer);
            atrc_pkg::OFS_AUX_A:      next_rdata = 32'(aux_a_value);
            atrc_pkg::OFS_AUX_B:      next_rdata = 32'(aux_b_value);
            atrc_pkg::OFS_IRQ_CTRL:   next_rdata = 32'({irq_en, 1'b0, irq_flag});
            default:                  next_rdata = 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else begin
         aw_held      <= next_aw_held;
         w_held       <= next_w_held;
         aw_addr      <= next_aw_addr;
         w_data       <= next_w_data;
         w_strb       <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp  <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rresp;
      end
   end
endmodule
